// ### alu_core.sv
// Function
// - add and add-carry set ZCNVH, one cycle
// - word add immediate sets ZCNVS, two cycles
// - word subtract immediate sets ZCNVS, two cycles
// - subtract register or constant sets ZCNVH
// - subtract-with-carry removes operand and carry
// - and, and-immediate, xor update Z N V
// - or and or-immediate update Z N V
// - set bits equals or with mask
// - flag bits clear on written one
// - io bit ops rewrite whole register
// - io bit ops reach only $00-$1F
`timescale 1ns/1ps
module alu_core
  import alu_pkg::*;
#(
  parameter int          WIDTH    = 8,
  parameter logic [7:0]  W1C_BITS = 8'h80
)
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             start_i,
  input  wire alu_op_t          op_i,
  input  wire logic [WIDTH-1:0] rd_i,
  input  wire logic [WIDTH-1:0] rd_hi_i,
  input  wire logic [WIDTH-1:0] rr_i,
  input  wire logic [7:0]       io_addr_i,
  input  wire logic [2:0]       io_bit_i,
  input  wire logic [7:0]       flags_i,
  input  wire logic             evt_set_i,
  input  wire logic [4:0]       evt_addr_i,
  input  wire logic [7:0]       evt_bits_i,
  output logic [WIDTH-1:0]      result_o,
  output logic [WIDTH-1:0]      result_hi_o,
  output logic [7:0]            flags_o,
  output logic                  wr_o,
  output logic                  wr_word_o,
  output logic                  busy_o,
  output logic                  io_reject_o
);
  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic [7:0] logic_flags(input logic [7:0] f,
                                             input logic [7:0] r);
    logic [7:0] o;
    o = f;
    o[ALU_FLAG_Z] = (r == 8'h00);
    o[ALU_FLAG_N] = r[7];
    o[ALU_FLAG_V] = 1'b0;
    // sign and the other flags pass through: only Z N V change
    return o;
  endfunction

  // a - b - cin with borrow, overflow and half-borrow
  function automatic logic [7:0] sub_flags(input logic [7:0] f,
                                           input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic [7:0] r);
    logic [7:0] o;
    o = f;
    o[ALU_FLAG_Z] = (r == 8'h00);
    o[ALU_FLAG_N] = r[7];
    o[ALU_FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    o[ALU_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    o[ALU_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    o[ALU_FLAG_S] = o[ALU_FLAG_N] ^ o[ALU_FLAG_V];
    return o;
  endfunction

  // word ops run a second cycle through the 16-bit adder
  function automatic logic is_word(input alu_op_t o);
    return (o == ALU_WORD_ADD_IMM_OP) || (o == ALU_WORD_SUBTRACT_IMM_OP);
  endfunction

  // ==========================================================
  // state
  // ==========================================================
  alu_state_t       state;
  logic [15:0]      word_q;
  logic             word_sub;
  logic [5:0]       word_k;
  logic [2:0]       bit_q;
  logic             set_q;
  logic [4:0]       addr_q;
  logic [WIDTH-1:0] next_result;
  logic [7:0]       next_flags;
  logic             next_wr;
  logic [16:0]      wsum;

  alu_io_if io();

  alu_io_space #(
    .DEPTH    (32),
    .W1C_BITS (W1C_BITS)
  ) u_io (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .evt_set_i  (evt_set_i),
    .evt_addr_i (evt_addr_i),
    .evt_bits_i (evt_bits_i),
    .io         (io.space)
  );

  wire logic io_ok = (io_addr_i <= ALU_IO_BIT_TOP);
  wire logic io_op = (op_i == ALU_IO_BIT_SET_OP) ||
                     (op_i == ALU_IO_BIT_CLEAR_OP);
  wire logic take  = start_i && (state == ALU_ST_IDLE);

  // read request issued when an in-range bit op is accepted
  assign io.rd_en   = take && io_op && io_ok;
  // the write cycle uses the address captured when the op was taken
  assign io.addr    = (state == ALU_ST_IO) ? addr_q
                                           : io_addr_i[ALU_IO_ADDR_W-1:0];
  assign io.wr_en   = (state == ALU_ST_IO);
  // whole byte rewritten; set flags go back as one and clear
  assign io.wr_data = set_q ? (io.rd_data | (8'h01 << bit_q))
                            : (io.rd_data & ~(8'h01 << bit_q));

  // ==========================================================
  // single-cycle byte operations
  // ==========================================================
  always_comb
  begin
    logic [8:0] s;
    logic [7:0] b;
    s = 9'h000;
    b = 8'h00;
    next_result = rd_i;
    next_flags  = flags_i;
    next_wr     = 1'b1;
    case (op_i)
      ALU_ADD, ALU_ADD_CARRY:
      begin
        s = {1'b0, rd_i} + {1'b0, rr_i} +
            {8'h00, (op_i == ALU_ADD_CARRY) & flags_i[ALU_FLAG_C]};
        next_result = s[7:0];
        next_flags[ALU_FLAG_Z] = (s[7:0] == 8'h00);
        next_flags[ALU_FLAG_C] = s[8];
        next_flags[ALU_FLAG_N] = s[7];
        next_flags[ALU_FLAG_V] = (rd_i[7] == rr_i[7]) && (s[7] != rd_i[7]);
        next_flags[ALU_FLAG_H] = (rd_i[3] & rr_i[3]) | (rr_i[3] & ~s[3]) |
                                 (~s[3] & rd_i[3]);
        next_flags[ALU_FLAG_S] = next_flags[ALU_FLAG_N] ^
                                 next_flags[ALU_FLAG_V];
      end
      ALU_SUBTRACT, ALU_SUBTRACT_IMM_OP:
      begin
        next_result = rd_i - rr_i;
        next_flags  = sub_flags(flags_i, rd_i, rr_i, next_result);
      end
      ALU_SUBTRACT_CARRY_OP, ALU_SUBTRACT_CARRY_IMM_OP:
      begin
        next_result = rd_i - rr_i - {7'h00, flags_i[ALU_FLAG_C]};
        next_flags  = sub_flags(flags_i, rd_i, rr_i, next_result);
      end
      ALU_AND, ALU_AND_IMM_OP:
      begin
        next_result = rd_i & rr_i;
        next_flags  = logic_flags(flags_i, next_result);
      end
      ALU_XOR_OP:
      begin
        next_result = rd_i ^ rr_i;
        next_flags  = logic_flags(flags_i, next_result);
      end
      ALU_OR, ALU_OR_IMM_OP, ALU_SET_BITS_OP:
      begin
        next_result = rd_i | rr_i;
        next_flags  = logic_flags(flags_i, next_result);
      end
      ALU_ONES_COMPLEMENT_OP:
      begin
        next_result = ALU_ALL_ONES - rd_i;
        next_flags  = logic_flags(flags_i, next_result);
        next_flags[ALU_FLAG_C] = 1'b1;
      end
      ALU_TWOS_COMPLEMENT_OP:
      begin
        b = rd_i;
        next_result = 8'h00 - b;
        next_flags  = sub_flags(flags_i, 8'h00, b, next_result);
      end
      default:
        next_wr = 1'b0;
    endcase
  end

  // ==========================================================
  // sequencing: byte ops one cycle, word ops two
  // ==========================================================
  assign wsum = word_sub ? ({1'b0, word_q} - {11'h000, word_k})
                         : ({1'b0, word_q} + {11'h000, word_k});

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state    <= ALU_ST_IDLE;
      word_q   <= 16'h0000;
      word_sub <= 1'b0;
      word_k   <= 6'h00;
      bit_q    <= 3'h0;
      set_q    <= 1'b0;
      addr_q   <= 5'h00;
    end
    else
    begin
      case (state)
        ALU_ST_IDLE:
          if (take)
          begin
            word_q   <= {rd_hi_i, rd_i};
            word_k   <= rr_i[5:0];
            word_sub <= (op_i == ALU_WORD_SUBTRACT_IMM_OP);
            bit_q    <= io_bit_i;
            set_q    <= (op_i == ALU_IO_BIT_SET_OP);
            addr_q   <= io_addr_i[ALU_IO_ADDR_W-1:0];
            if (is_word(op_i))
              state <= ALU_ST_WORD;
            else if (io_op && io_ok)
              state <= ALU_ST_IO;
          end
        ALU_ST_WORD: state <= ALU_ST_IDLE;
        ALU_ST_IO:   state <= ALU_ST_IDLE;
        default:     state <= ALU_ST_IDLE;
      endcase
    end
  end

  // registered results and flags
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      result_o    <= '0;
      result_hi_o <= '0;
      flags_o     <= ALU_FLAGS_RESET;
      wr_o        <= 1'b0;
      wr_word_o   <= 1'b0;
      io_reject_o <= 1'b0;
    end
    else
    begin
      wr_o        <= 1'b0;
      wr_word_o   <= 1'b0;
      io_reject_o <= take && io_op && !io_ok;
      if (state == ALU_ST_WORD)
      begin
        result_o    <= wsum[7:0];
        result_hi_o <= wsum[15:8];
        wr_word_o   <= 1'b1;
        flags_o[ALU_FLAG_Z] <= (wsum[15:0] == 16'h0000);
        flags_o[ALU_FLAG_C] <= wsum[16];
        flags_o[ALU_FLAG_N] <= wsum[15];
        flags_o[ALU_FLAG_V] <= word_sub ? (word_q[15] & ~wsum[15])
                                        : (~word_q[15] & wsum[15]);
        flags_o[ALU_FLAG_S] <= wsum[15] ^ (word_sub ?
                                 (word_q[15] & ~wsum[15]) :
                                 (~word_q[15] & wsum[15]));
      end
      else if (take && !io_op && next_wr)
      begin
        result_o <= next_result;
        flags_o  <= next_flags;
        wr_o     <= 1'b1;
      end
    end
  end

  // busy while the second cycle of a word or io op runs
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      busy_o <= 1'b0;
    else
      busy_o <= take && (io_op ? io_ok : is_word(op_i));
  end
endmodule

// ### alu_core_properties.sv
`timescale 1ns/1ps
module alu_core_properties
  import alu_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic             ref_clk_i,
  input wire logic             rst_n_i,
  input wire logic             start_i,
  input wire alu_op_t          op_i,
  input wire logic [WIDTH-1:0] rd_i,
  input wire logic [WIDTH-1:0] rd_hi_i,
  input wire logic [WIDTH-1:0] rr_i,
  input wire logic [7:0]       io_addr_i,
  input wire logic [2:0]       io_bit_i,
  input wire logic [7:0]       flags_i,
  input wire logic             evt_set_i,
  input wire logic [4:0]       evt_addr_i,
  input wire logic [7:0]       evt_bits_i,
  input wire logic [WIDTH-1:0] result_o,
  input wire logic [WIDTH-1:0] result_hi_o,
  input wire logic [7:0]       flags_o,
  input wire logic             wr_o,
  input wire logic             wr_word_o,
  input wire logic             busy_o,
  input wire logic             io_reject_o
);
  // ==========================================================
  // acceptance
  // ==========================================================
  // a start in the second cycle of a word op is not a request
  logic go;
  assign go = start_i && !busy_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_byte_time;
    go && op_i < ALU_WORD_ADD_IMM_OP |=> wr_o && !wr_word_o && !busy_o;
  endproperty
  a_byte_time: assert property (p_byte_time)
    else $error("byte op did not finish in one cycle");
  property p_word_time;
    go && op_i inside {ALU_WORD_ADD_IMM_OP, ALU_WORD_SUBTRACT_IMM_OP}
      |=> busy_o && !wr_word_o ##1 wr_word_o && !busy_o;
  endproperty
  a_word_time: assert property (p_word_time)
    else $error("word op did not finish in two cycles");
  property p_word_add;
    go && op_i == ALU_WORD_ADD_IMM_OP |=> ##1 {result_hi_o, result_o}
      == $past({rd_hi_i, rd_i}, 2) + $past(rr_i[5:0], 2);
  endproperty
  a_word_add: assert property (p_word_add)
    else $error("word add result wrong");
  property p_word_sub;
    go && op_i == ALU_WORD_SUBTRACT_IMM_OP |=> ##1 {result_hi_o, result_o}
      == $past({rd_hi_i, rd_i}, 2) - $past(rr_i[5:0], 2);
  endproperty
  a_word_sub: assert property (p_word_sub)
    else $error("word subtract result wrong");
  property p_add_carry;
    go && op_i == ALU_ADD_CARRY |=> result_o
      == $past(rd_i) + $past(rr_i) + $past(flags_i[ALU_FLAG_C]);
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add with carry result wrong");
  property p_sub_imm;
    go && op_i == ALU_SUBTRACT_IMM_OP |=> result_o == $past(rd_i - rr_i);
  endproperty
  a_sub_imm: assert property (p_sub_imm)
    else $error("subtract constant result wrong");
  property p_sub_carry;
    go && op_i == ALU_SUBTRACT_CARRY_OP |=> result_o
      == $past(rd_i) - $past(rr_i) - $past(flags_i[ALU_FLAG_C]);
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract with carry result wrong");
  property p_and_imm;
    go && op_i == ALU_AND_IMM_OP
      |=> result_o == $past(rd_i & rr_i) && !flags_o[ALU_FLAG_V];
  endproperty
  a_and_imm: assert property (p_and_imm)
    else $error("and constant wrong");
  property p_or_set;
    go && op_i inside {ALU_OR_IMM_OP, ALU_SET_BITS_OP}
      |=> result_o == $past(rd_i | rr_i);
  endproperty
  a_or_set: assert property (p_or_set)
    else $error("or or set bits wrong");
  property p_ones;
    go && op_i == ALU_ONES_COMPLEMENT_OP
      |=> result_o == ~$past(rd_i) && flags_o[ALU_FLAG_C];
  endproperty
  a_ones: assert property (p_ones)
    else $error("ones complement wrong");
  property p_zero_minus;
    wr_o |-> flags_o[ALU_FLAG_Z] == (result_o == 8'h00)
      && flags_o[ALU_FLAG_N] == result_o[7];
  endproperty
  a_zero_minus: assert property (p_zero_minus)
    else $error("zero or negative flag wrong");
  property p_io_reach;
    go && op_i inside {ALU_IO_BIT_SET_OP, ALU_IO_BIT_CLEAR_OP}
      |=> io_reject_o == $past(io_addr_i > ALU_IO_BIT_TOP);
  endproperty
  a_io_reach: assert property (p_io_reach)
    else $error("io bit op reach wrong");
endmodule

// ### alu_io_if.sv
`timescale 1ns/1ps
// read-modify-write path toward the low i/o space
interface alu_io_if;
  logic       rd_en;
  logic [4:0] addr;
  logic [7:0] rd_data;
  logic [7:0] w1c_mask;
  logic       wr_en;
  logic [7:0] wr_data;

  modport core
  (
    output rd_en,
    output addr,
    input  rd_data,
    input  w1c_mask,
    output wr_en,
    output wr_data
  );
  modport space
  (
    input  rd_en,
    input  addr,
    output rd_data,
    output w1c_mask,
    input  wr_en,
    input  wr_data
  );
endinterface

// ### alu_io_space.sv
`timescale 1ns/1ps
// ==========================================================
// low i/o register file with write-one-to-clear flag bits
// ==========================================================
module alu_io_space
  import alu_pkg::*;
#(
  parameter int          DEPTH    = 32,
  parameter logic [7:0]  W1C_BITS = 8'h80
)
(
  input  wire logic      ref_clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      evt_set_i,
  input  wire logic [4:0] evt_addr_i,
  input  wire logic [7:0] evt_bits_i,
  alu_io_if.space        io
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rd_q;

  assign io.rd_data  = rd_q;
  assign io.w1c_mask = W1C_BITS;

  // flag bits that hardware raises at one location this cycle
  function automatic logic [7:0] hw_bits(input logic [4:0] a);
    return (evt_set_i && evt_addr_i == a) ? (evt_bits_i & W1C_BITS)
                                          : 8'h00;
  endfunction

  // registered read port
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      rd_q <= 8'h00;
    else if (io.rd_en)
      rd_q <= mem[io.addr];
  end

  // plain bits take the write; flag bits clear on one, hardware set wins
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (io.wr_en && io.addr == i[4:0])
          mem[i] <= (io.wr_data & ~W1C_BITS)
                  | (mem[i] & W1C_BITS & ~io.wr_data)
                  | hw_bits(i[4:0]);
        else
          mem[i] <= mem[i] | hw_bits(i[4:0]);
      end
    end
  end
endmodule

// ### alu_pkg.sv
package alu_pkg;

  // ==========================================================
  // operation codes
  // ==========================================================
  typedef enum logic [4:0] {
    ALU_ADD                   = 5'h00,
    ALU_ADD_CARRY             = 5'h01,
    ALU_SUBTRACT              = 5'h02,
    ALU_SUBTRACT_IMM_OP       = 5'h03,
    ALU_SUBTRACT_CARRY_OP     = 5'h04,
    ALU_SUBTRACT_CARRY_IMM_OP = 5'h05,
    ALU_AND                   = 5'h06,
    ALU_AND_IMM_OP            = 5'h07,
    ALU_OR                    = 5'h08,
    ALU_OR_IMM_OP             = 5'h09,
    ALU_XOR_OP                = 5'h0a,
    ALU_ONES_COMPLEMENT_OP    = 5'h0b,
    ALU_TWOS_COMPLEMENT_OP    = 5'h0c,
    ALU_SET_BITS_OP           = 5'h0d,
    ALU_WORD_ADD_IMM_OP       = 5'h0e,
    ALU_WORD_SUBTRACT_IMM_OP  = 5'h0f,
    ALU_IO_BIT_SET_OP         = 5'h10,
    ALU_IO_BIT_CLEAR_OP       = 5'h11
  } alu_op_t;

  // ==========================================================
  // word and io bit-op pipeline states
  // ==========================================================
  typedef enum logic [1:0] {
    ALU_ST_IDLE = 2'b00,
    ALU_ST_WORD = 2'b01,
    ALU_ST_IO   = 2'b11
  } alu_state_t;

  // ==========================================================
  // flag positions in the status byte
  // ==========================================================
  localparam int ALU_FLAG_C = 0;
  localparam int ALU_FLAG_Z = 1;
  localparam int ALU_FLAG_N = 2;
  localparam int ALU_FLAG_V = 3;
  localparam int ALU_FLAG_S = 4;
  localparam int ALU_FLAG_H = 5;

  localparam logic [7:0] ALU_FLAGS_RESET = 8'h00;
  localparam logic [7:0] ALU_ALL_ONES    = 8'hff;
  localparam logic [7:0] ALU_IO_BIT_TOP  = 8'h1f; // last bit-op address
  localparam int         ALU_IO_ADDR_W   = 5;     // $00..$1F reach

  // ==========================================================
  // cycle counts
  // ==========================================================
  localparam int ALU_BYTE_CYCLES = 1;
  localparam int ALU_WORD_CYCLES = 2;

endpackage

// ### test_eight_bit_arith_logic_unit.sv
`timescale 1ns/1ps
module test_eight_bit_arith_logic_unit
  import alu_pkg::*;
;
  logic       ref_clk_i, rst_n_i, start_i, evt_set_i;
  alu_op_t    op_i;
  logic [7:0] rd_i, rd_hi_i, rr_i, io_addr_i, flags_i, evt_bits_i;
  logic [2:0] io_bit_i;
  logic [4:0] evt_addr_i;
  logic [7:0] result_o, result_hi_o, flags_o;
  logic       wr_o, wr_word_o, busy_o, io_reject_o;
  int         num_errors, num_checks;

  alu_core u_alu_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .start_i(start_i), .op_i(op_i), .rd_i(rd_i), .rd_hi_i(rd_hi_i),
    .rr_i(rr_i), .io_addr_i(io_addr_i), .io_bit_i(io_bit_i),
    .flags_i(flags_i), .evt_set_i(evt_set_i), .evt_addr_i(evt_addr_i),
    .evt_bits_i(evt_bits_i), .result_o(result_o),
    .result_hi_o(result_hi_o), .flags_o(flags_o), .wr_o(wr_o),
    .wr_word_o(wr_word_o), .busy_o(busy_o), .io_reject_o(io_reject_o));

  // ==========================================================
  // clock, verdict, helpers
  // ==========================================================
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic summarize;
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail(input string m);
    num_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  // expected byte result, flags and mask of flags that must match
  task automatic calc(input alu_op_t op, input logic [7:0] d, r, f,
                      output logic [7:0] y, e, m);
    logic [8:0] s;
    logic       h, v, c, sf;
    c = f[ALU_FLAG_C];
    h = f[ALU_FLAG_H];
    v = 1'b0;
    m = 8'h3f;
    case (op)
      ALU_ADD, ALU_ADD_CARRY:
      begin
        c = (op == ALU_ADD) ? 1'b0 : c;
        s = d + r + c;
        h = (d[3:0] + r[3:0] + c) > 5'h0f;
        v = (d[7] == r[7]) && (s[7] != d[7]);
      end
      ALU_SUBTRACT, ALU_SUBTRACT_IMM_OP, ALU_SUBTRACT_CARRY_OP,
      ALU_SUBTRACT_CARRY_IMM_OP:
      begin
        c = (op inside {ALU_SUBTRACT, ALU_SUBTRACT_IMM_OP}) ? 1'b0 : c;
        s = d - r - c;
        h = {1'b0, d[3:0]} < r[3:0] + c;
        v = (d[7] != r[7]) && (s[7] != d[7]);
      end
      ALU_TWOS_COMPLEMENT_OP:
      begin
        s = {d != 8'h00, 8'h00 - d};
        h = d[3:0] != 4'h0;
        v = d == 8'h80;
      end
      ALU_ONES_COMPLEMENT_OP:
      begin
        s = {1'b1, ~d};
      end
      ALU_AND, ALU_AND_IMM_OP: s = {c, d & r};
      ALU_OR, ALU_OR_IMM_OP, ALU_SET_BITS_OP: s = {c, d | r};
      default: s = {c, d ^ r};
    endcase
    y = s[7:0];
    // arithmetic gives S = N ^ V; logic ops and ones complement keep S
    sf = (op < ALU_AND || op == ALU_TWOS_COMPLEMENT_OP) ? y[7] ^ v
                                                         : f[ALU_FLAG_S];
    e = {2'b00, h, sf, v, y[7], y == 8'h00, s[8]};
  endtask

  // ==========================================================
  // drivers: entered at a falling edge, left at a falling edge
  // ==========================================================
  // start stays high so consecutive calls run back to back
  task automatic do_byte(input alu_op_t op, input logic [7:0] d, r, f);
    logic [7:0] y, e, m;
    calc(op, d, r, f, y, e, m);
    start_i = 1'b1;
    op_i = op;
    rd_i = d;
    rr_i = r;
    flags_i = f;
    @(negedge ref_clk_i);
    num_checks++;
    if (wr_o !== 1'b1 || result_o !== y || (flags_o & m) !== (e & m))
      fail("byte result or flags");
  endtask
  task automatic idle;
    start_i = 1'b0;
    @(negedge ref_clk_i);
  endtask
  // a byte op offered in the busy cycle must be ignored
  task automatic do_word(input alu_op_t op, input logic [15:0] w,
                         input logic [5:0] k);
    logic [16:0] s;
    logic        v;
    s = (op == ALU_WORD_ADD_IMM_OP) ? w + k : w - k;
    v = (op == ALU_WORD_ADD_IMM_OP) ? !w[15] && s[15] : w[15] && !s[15];
    start_i = 1'b1;
    op_i = op;
    {rd_hi_i, rd_i} = w;
    rr_i = {2'b11, k}; // top bits are not part of the constant
    @(negedge ref_clk_i);
    op_i = ALU_ADD;
    num_checks++;
    if (busy_o !== 1'b1 || wr_word_o !== 1'b0)
      fail("word first cycle");
    @(negedge ref_clk_i);
    start_i = 1'b0;
    num_checks++;
    if (wr_word_o !== 1'b1 || wr_o !== 1'b0
        || {result_hi_o, result_o} !== s[15:0] || (flags_o & 8'h1f)
        !== {3'b000, s[15] ^ v, v, s[15], s[15:0] == 16'h0000, s[16]})
      fail("word result or flags");
    @(negedge ref_clk_i);
  endtask
  // ev[0] raises a flag in the take cycle, ev[1] in the write cycle
  task automatic do_io(input alu_op_t op, input logic [7:0] a,
                       input logic [1:0] ev, input logic [7:0] x);
    start_i = 1'b1;
    op_i = op;
    io_addr_i = a;
    io_bit_i = 3'h3; // defined bits only, no reserved write
    evt_set_i = ev[0];
    evt_addr_i = a[4:0];
    @(negedge ref_clk_i);
    start_i = 1'b0;
    evt_set_i = ev[1];
    io_addr_i = ~a; // the write must use the address taken at the start
    num_checks++;
    if (io_reject_o !== (a > ALU_IO_BIT_TOP))
      fail("io bit op reach");
    @(negedge ref_clk_i);
    evt_set_i = 1'b0;
    num_checks++;
    if (u_alu_core.u_io.mem[a[4:0]] !== x)
      fail("io byte after bit op");
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_add;
    do_byte(ALU_ADD, 8'h0f, 8'h01, 8'h00);
    do_byte(ALU_ADD, 8'h7f, 8'h01, 8'h01);
    do_byte(ALU_ADD, 8'hff, 8'h01, 8'h00);
    do_byte(ALU_ADD_CARRY, 8'h0e, 8'h01, 8'h01);
    do_byte(ALU_ADD_CARRY, 8'hff, 8'h00, 8'h01);
  endtask
  task automatic t_sub;
    do_byte(ALU_SUBTRACT, 8'h00, 8'h01, 8'h00);
    do_byte(ALU_SUBTRACT_IMM_OP, 8'h80, 8'h01, 8'h01);
    do_byte(ALU_SUBTRACT_CARRY_OP, 8'h10, 8'h01, 8'h01);
    do_byte(ALU_SUBTRACT_CARRY_IMM_OP, 8'h20, 8'h0f, 8'h01);
  endtask
  task automatic t_logic;
    do_byte(ALU_AND, 8'hf0, 8'h3c, 8'h21);
    do_byte(ALU_AND_IMM_OP, 8'h0f, 8'hf0, 8'h21);
    do_byte(ALU_XOR_OP, 8'haa, 8'haa, 8'h21);
    do_byte(ALU_OR, 8'h80, 8'h01, 8'h00);
    do_byte(ALU_OR_IMM_OP, 8'h00, 8'h00, 8'h21);
    do_byte(ALU_SET_BITS_OP, 8'h01, 8'h80, 8'h00);
  endtask
  task automatic t_compl;
    do_byte(ALU_ONES_COMPLEMENT_OP, 8'h00, 8'h00, 8'h00);
    do_byte(ALU_ONES_COMPLEMENT_OP, 8'hff, 8'h00, 8'h00);
    do_byte(ALU_TWOS_COMPLEMENT_OP, 8'h00, 8'h00, 8'h01);
    do_byte(ALU_TWOS_COMPLEMENT_OP, 8'h80, 8'h00, 8'h00);
    do_byte(ALU_TWOS_COMPLEMENT_OP, 8'h01, 8'h00, 8'h00);
  endtask

  initial
  begin
    {start_i, evt_set_i, rd_i, rd_hi_i, rr_i, io_addr_i} = '0;
    {flags_i, evt_bits_i, io_bit_i, evt_addr_i} = '0;
    op_i = ALU_ADD;
    rst_n_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    evt_bits_i = 8'h80;
    t_add();
    t_sub();
    t_logic();
    t_compl();
    idle();
    do_word(ALU_WORD_ADD_IMM_OP, 16'hffff, 6'h01);
    do_word(ALU_WORD_ADD_IMM_OP, 16'h7fff, 6'h01);
    do_word(ALU_WORD_SUBTRACT_IMM_OP, 16'h0000, 6'h01);
    do_word(ALU_WORD_SUBTRACT_IMM_OP, 16'h8000, 6'h3f);
    do_io(ALU_IO_BIT_SET_OP, 8'h1f, 2'b01, 8'h88);
    do_io(ALU_IO_BIT_CLEAR_OP, 8'h1f, 2'b10, 8'h80);
    do_io(ALU_IO_BIT_CLEAR_OP, 8'h1f, 2'b00, 8'h00);
    do_io(ALU_IO_BIT_SET_OP, 8'h00, 2'b00, 8'h08);
    do_io(ALU_IO_BIT_CLEAR_OP, 8'h20, 2'b01, 8'h88);
    do_io(ALU_IO_BIT_SET_OP, 8'hff, 2'b00, 8'h00);
    summarize();
  end
  // the whole run is well under two hundred cycles
  initial
  begin
    repeat (3000) @(posedge ref_clk_i);
    fail("watchdog expired");
    summarize();
  end
endmodule

bind alu_core alu_core_properties #(.WIDTH(WIDTH)) u_alu_core_properties (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
  .op_i(op_i), .rd_i(rd_i), .rd_hi_i(rd_hi_i), .rr_i(rr_i),
  .io_addr_i(io_addr_i), .io_bit_i(io_bit_i), .flags_i(flags_i),
  .evt_set_i(evt_set_i), .evt_addr_i(evt_addr_i),
  .evt_bits_i(evt_bits_i), .result_o(result_o),
  .result_hi_o(result_hi_o), .flags_o(flags_o), .wr_o(wr_o),
  .wr_word_o(wr_word_o), .busy_o(busy_o), .io_reject_o(io_reject_o));
